// ---- logic/mkd_consts.svh ----
// Constants for the matrix keypad scancode decoder
//
// Function
// RQ1: Rows low, step column until low column found
// RQ2: Swap directions, step row until low row
// RQ3: Processing first copies scancode to output word
// RQ4: Match alternation codes, update flags, copy flags
// RQ5: Ordinary key clears one-shot flags, locks stay
// RQ6: Last processing step sets the new-key flag
// RQ7: Scancode equals row times eight plus column
// RQ8: Consumer tables keep eight entries per row
// RQ9: Output lines driven low, inputs pulled high
// RQ10: Code in low six bits, new flag bit 15
// RQ11: Three lock keys toggle, four one-shot keys
// RQ12: Idle holds rows low, column low starts scan
// RQ13: Wait programmable debounce before scanning
// RQ14: No low column at scan abandons without update
`ifndef MKD_CONSTS_SVH
`define MKD_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define MKD_OFF_OUT      4'h0
`define MKD_OFF_FLAGS    4'h4
`define MKD_OFF_STAT     4'h8
`define MKD_OFF_MASK     4'hC

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define MKD_NEW_BIT      15
`define MKD_STAT_KEY     0
`define MKD_STAT_ABORT   1
`define MKD_MASK_RST     2'h0
`define MKD_NUM_LOCK     3
`define MKD_NUM_SHOT     4
`define MKD_NUM_ALT      7

// ----------------------------------------------------------------------
// Alternation key codes, locks first then one-shots
// ----------------------------------------------------------------------
`define MKD_ALT_CODES    42'h0_0000_0000_0000

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define MKD_CLK_HZ       50000000
`define MKD_DEBOUNCE_US  5000
`define MKD_DEBOUNCE_CYC (`MKD_CLK_HZ / 1000000 * `MKD_DEBOUNCE_US)

`endif

// ---- logic/mkd_pkg.sv ----
// Types for the matrix keypad scancode decoder
package mkd_pkg;

  typedef enum logic [2:0] {
    MKD_IDLE   = 3'b000,
    MKD_BOUNCE = 3'b001,
    MKD_COL    = 3'b011,
    MKD_SWAP   = 3'b010,
    MKD_ROW    = 3'b110,
    MKD_PROC   = 3'b111,
    MKD_FLAG   = 3'b101,
    MKD_DONE   = 3'b100
  } mkd_state_e;

  typedef logic [5:0] mkd_code_t;

endpackage

// ---- logic/mkd_res_if.sv ----
// Scan result handed from the scanner to the register side
`timescale 1ns/10ps
interface mkd_res_if;
  logic [5:0] code;   // Scancode of the key found
  logic       valid;  // One-cycle pulse: key decoded
  logic       abort;  // One-cycle pulse: scan abandoned

  modport scan (output code, output valid, output abort);
  modport sink (input code, input valid, input abort);
endinterface

// ---- logic/mkd_scan.sv ----
// Key matrix scanner: detect, debounce, column then row search
`timescale 1ns/10ps
`include "mkd_consts.svh"
module mkd_scan #(
  parameter int unsigned DEBOUNCE_CYC = `MKD_DEBOUNCE_CYC
) (
  input  wire logic  clk_i,          // System clock
  input  wire logic  rst_i,          // Synchronous reset
  input  wire logic [7:0] col_s_i,   // Synchronised column inputs
  input  wire logic [7:0] row_s_i,   // Synchronised row inputs
  output logic       rows_drv_r_o,   // High: rows driven low
  output logic       cols_drv_r_o,   // High: columns driven low
  mkd_res_if.scan    res             // Scan result
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  mkd_pkg::mkd_state_e state_r;
  mkd_pkg::mkd_code_t  code_r;
  logic [22:0]         cnt_r;
  logic                col_hit;
  logic                row_hit;

  assign col_hit = (col_s_i[code_r[2:0]] == 1'b0);
  assign row_hit = (row_s_i[code_r[5:3]] == 1'b0);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= mkd_pkg::MKD_IDLE;
    end else begin
      case (state_r)
        mkd_pkg::MKD_IDLE: begin
          if (col_s_i != 8'hFF)                                 // RQ12
            state_r <= mkd_pkg::MKD_BOUNCE;
        end
        mkd_pkg::MKD_BOUNCE: begin
          if (cnt_r == 23'(DEBOUNCE_CYC - 1)) begin             // RQ13
            if (col_s_i == 8'hFF)
              state_r <= mkd_pkg::MKD_DONE;                     // RQ14
            else
              state_r <= mkd_pkg::MKD_COL;
          end
        end
        mkd_pkg::MKD_COL: begin
          if (col_hit)                                          // RQ1
            state_r <= mkd_pkg::MKD_SWAP;
          else if (code_r[2:0] == 3'h7)
            state_r <= mkd_pkg::MKD_DONE;
        end
        mkd_pkg::MKD_SWAP: begin
          if (cnt_r[1:0] == 2'h3)
            state_r <= mkd_pkg::MKD_ROW;
        end
        mkd_pkg::MKD_ROW: begin
          if (row_hit)                                          // RQ2
            state_r <= mkd_pkg::MKD_PROC;
          else if (code_r[5:3] == 3'h7)
            state_r <= mkd_pkg::MKD_DONE;
        end
        mkd_pkg::MKD_PROC: state_r <= mkd_pkg::MKD_FLAG;
        mkd_pkg::MKD_FLAG: state_r <= mkd_pkg::MKD_DONE;
        mkd_pkg::MKD_DONE: begin
          // After a row scan all lines were released for a cycle; let that pass the
          // synchroniser so a held key is not seen as released
          if (cnt_r[2:0] == 3'h7 && col_s_i == 8'hFF)           // RQ12
            state_r <= mkd_pkg::MKD_IDLE;
        end
        default: state_r <= mkd_pkg::MKD_IDLE;
      endcase
    end
  end

  // Debounce and settle counter
  always_ff @(posedge clk_i) begin
    if (rst_i)
      cnt_r <= 23'h0;
    else if (state_r == mkd_pkg::MKD_BOUNCE ||
             state_r == mkd_pkg::MKD_SWAP ||
             (state_r == mkd_pkg::MKD_DONE && cnt_r[2:0] != 3'h7))
      cnt_r <= cnt_r + 23'h1;
    else
      cnt_r <= 23'h0;
  end

  // Scancode: row * 8 + column
  always_ff @(posedge clk_i) begin
    if (rst_i)
      code_r <= 6'h00;
    else if (state_r == mkd_pkg::MKD_IDLE)
      code_r <= 6'h00;
    else if (state_r == mkd_pkg::MKD_COL && !col_hit)
      code_r[2:0] <= code_r[2:0] + 3'h1;                        // RQ1
    else if (state_r == mkd_pkg::MKD_ROW && !row_hit)
      code_r[5:3] <= code_r[5:3] + 3'h1;                        // RQ7
  end

  // Drive direction: rows in idle and column scan, columns in row scan
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rows_drv_r_o <= 1'b1;
      cols_drv_r_o <= 1'b0;
    end else begin
      rows_drv_r_o <= !(state_r == mkd_pkg::MKD_COL && col_hit) &&
                      state_r != mkd_pkg::MKD_SWAP &&
                      state_r != mkd_pkg::MKD_ROW;              // RQ9
      cols_drv_r_o <= (state_r == mkd_pkg::MKD_COL && col_hit) ||
                      state_r == mkd_pkg::MKD_SWAP ||
                      (state_r == mkd_pkg::MKD_ROW && !row_hit &&
                       code_r[5:3] != 3'h7);                    // RQ2
    end
  end

  assign res.code  = code_r;
  assign res.valid = (state_r == mkd_pkg::MKD_PROC);
  assign res.abort = (state_r == mkd_pkg::MKD_BOUNCE &&
                      cnt_r == 23'(DEBOUNCE_CYC - 1) &&
                      col_s_i == 8'hFF);

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  col_found_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_r == mkd_pkg::MKD_COL && col_hit |=>
      state_r == mkd_pkg::MKD_SWAP)                             // RQ1
    else $error("column hit did not move to swap");
  row_found_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_r == mkd_pkg::MKD_ROW && row_hit |=>
      state_r == mkd_pkg::MKD_PROC && $stable(code_r))          // RQ2
    else $error("row hit did not move to processing");
  idle_rows_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(state_r) == mkd_pkg::MKD_IDLE |->
      rows_drv_r_o && !cols_drv_r_o)                            // RQ12
    else $error("rows not driven in idle");
  bounce_wait_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_r == mkd_pkg::MKD_BOUNCE && cnt_r != 23'(DEBOUNCE_CYC - 1)
      |=> state_r == mkd_pkg::MKD_BOUNCE)                       // RQ13
    else $error("left debounce early");
  no_clash_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(rows_drv_r_o && cols_drv_r_o))                            // RQ9
    else $error("rows and columns driven together");
  done_settle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_r == mkd_pkg::MKD_DONE && cnt_r[2:0] != 3'h7 |=>
      state_r == mkd_pkg::MKD_DONE)                             // RQ12
    else $error("left key release wait before settling");

endmodule

// ---- logic/mkd_top.sv ----
// Matrix keypad scancode decoder top with Wishbone registers
//
// The implementer's own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/10ps
`include "mkd_consts.svh"
module mkd_top #(
  parameter int unsigned DEBOUNCE_CYC = `MKD_DEBOUNCE_CYC
) (
  input  wire logic        clk_i,      // System clock, 50 MHz
  input  wire logic        rst_i,      // Synchronous reset
  input  wire logic        wb_cyc_i,   // Wishbone cycle
  input  wire logic        wb_stb_i,   // Wishbone strobe
  input  wire logic        wb_we_i,    // Wishbone write enable
  input  wire logic [3:0]  wb_adr_i,   // Wishbone byte address
  input  wire logic [3:0]  wb_sel_i,   // Wishbone byte selects
  input  wire logic [31:0] wb_dat_i,   // Wishbone write data
  output logic      [31:0] wb_dat_o,   // Wishbone read data
  output logic             wb_ack_o,   // Wishbone acknowledge
  output logic             irq_o,      // Level interrupt
  input  wire logic [7:0]  row_i,      // Row pin levels
  output logic      [7:0]  row_o,      // Row pin drive values
  output logic      [7:0]  row_oe_n_o, // Row enables, low drives
  input  wire logic [7:0]  col_i,      // Column pin levels
  output logic      [7:0]  col_o,      // Column pin drive values
  output logic      [7:0]  col_oe_n_o  // Column enables, low drives
);

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  logic [7:0] row_m_r;
  logic [7:0] row_s_r;
  logic [7:0] col_m_r;
  logic [7:0] col_s_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      row_m_r <= 8'hFF;
      row_s_r <= 8'hFF;
      col_m_r <= 8'hFF;
      col_s_r <= 8'hFF;
    end else begin
      row_m_r <= row_i;
      row_s_r <= row_m_r;
      col_m_r <= col_i;
      col_s_r <= col_m_r;
    end
  end

  // --------------------------------------------------------------------
  // Scanner
  // --------------------------------------------------------------------
  mkd_res_if res ();
  logic rows_drv;
  logic cols_drv;

  mkd_scan #(
    .DEBOUNCE_CYC (DEBOUNCE_CYC)
  ) u_scan (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .col_s_i      (col_s_r),
    .row_s_i      (row_s_r),
    .rows_drv_r_o (rows_drv),
    .cols_drv_r_o (cols_drv),
    .res          (res.scan)
  );

  // Pin drive registers: driven lines low, others released to pull-up
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      row_o      <= 8'h00;
      col_o      <= 8'h00;
      row_oe_n_o <= 8'hFF;
      col_oe_n_o <= 8'hFF;
    end else begin
      row_o      <= 8'h00;                                      // RQ9
      col_o      <= 8'h00;
      row_oe_n_o <= rows_drv ? 8'h00 : 8'hFF;
      col_oe_n_o <= cols_drv ? 8'h00 : 8'hFF;
    end
  end

  // --------------------------------------------------------------------
  // Alternation key processing
  // --------------------------------------------------------------------
  localparam logic [41:0] ALT_CODES = `MKD_ALT_CODES;

  logic [6:0]  alt_r;
  logic [6:0]  alt_hit;
  logic [15:0] out_r;
  logic        proc_r;

  always_comb begin
    alt_hit = 7'h00;
    for (int i = 0; i < `MKD_NUM_ALT; i++)
      alt_hit[i] = (res.code == ALT_CODES[i*6 +: 6]);           // RQ4
  end

  // Lock bits 2:0 toggle, one-shot bits 6:3 set; ordinary clears shots
  always_ff @(posedge clk_i) begin
    if (rst_i)
      alt_r <= 7'h00;
    else if (res.valid) begin
      if (alt_hit == 7'h00)
        alt_r[6:3] <= 4'h0;                                     // RQ5
      else begin
        alt_r[2:0] <= alt_r[2:0] ^ alt_hit[2:0];                // RQ11
        alt_r[6:3] <= alt_r[6:3] | alt_hit[6:3];
      end
    end
  end

  // Output word: code and flags on the same edge, then the new-key flag last
  logic clr_new;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_r  <= 16'h0000;
      proc_r <= 1'b0;
    end else begin
      proc_r <= res.valid;
      if (res.valid)
        out_r[5:0] <= res.code;                                 // RQ3
      if (proc_r)
        out_r[`MKD_NEW_BIT] <= 1'b1;                            // RQ6
      else if (clr_new)
        out_r[`MKD_NEW_BIT] <= 1'b0;                            // RQ10
    end
  end

  // Flags reported alongside the code as seen by the key itself
  logic [6:0] flags_r;
  always_ff @(posedge clk_i) begin
    if (rst_i)
      flags_r <= 7'h00;
    else if (res.valid)
      flags_r <= {alt_r[6:3] | alt_hit[6:3],
                  alt_r[2:0] ^ alt_hit[2:0]};                   // RQ4
  end

  // --------------------------------------------------------------------
  // Wishbone slave
  // --------------------------------------------------------------------
  logic       req;
  logic       wr;
  logic [1:0] stat_r;
  logic [1:0] mask_r;
  logic [1:0] ev;

  assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Writes land at the edge where the master samples ack high
  assign wr      = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign clr_new = wr && wb_adr_i == `MKD_OFF_OUT && wb_sel_i[1] &&
                   !wb_dat_i[`MKD_NEW_BIT];
  assign ev      = {res.abort, proc_r};

  always_ff @(posedge clk_i) begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= req;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (req && !wb_we_i) begin
      case (wb_adr_i)
        `MKD_OFF_OUT:   wb_dat_o <= {16'h0000, out_r};
        `MKD_OFF_FLAGS: wb_dat_o <= {25'h0, flags_r};
        `MKD_OFF_STAT:  wb_dat_o <= {30'h0, stat_r};
        `MKD_OFF_MASK:  wb_dat_o <= {30'h0, mask_r};
        default:        wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i)
      stat_r <= 2'h0;
    else if (wr && wb_adr_i == `MKD_OFF_STAT && wb_sel_i[0])
      stat_r <= (stat_r & ~wb_dat_i[1:0]) | ev;
    else
      stat_r <= stat_r | ev;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      mask_r <= `MKD_MASK_RST;
    else if (wr && wb_adr_i == `MKD_OFF_MASK && wb_sel_i[0])
      mask_r <= wb_dat_i[1:0];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |((stat_r | ev) & mask_r);
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  sequence key_done_s;
    res.valid ##1 proc_r;
  endsequence

  new_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    key_done_s |=> out_r[`MKD_NEW_BIT])                         // RQ6
    else $error("new-key flag not set after key");
  code_copy_a: assert property (@(posedge clk_i) disable iff (rst_i)
    res.valid |=> out_r[5:0] == $past(res.code))                // RQ3
    else $error("scancode not copied to output word");
  shot_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    res.valid && alt_hit == 7'h00 |=> alt_r[6:3] == 4'h0 &&
      alt_r[2:0] == $past(alt_r[2:0]))                          // RQ5
    else $error("one-shot flags not cleared");
  lock_toggle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    res.valid && alt_hit[0] |=> alt_r[0] != $past(alt_r[0]))    // RQ11
    else $error("lock flag did not toggle");
  abort_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    res.abort && !clr_new |=> $stable(out_r))                   // RQ14
    else $error("aborted scan changed output word");
  flag_copy_a: assert property (@(posedge clk_i) disable iff (rst_i)
    proc_r |-> flags_r == {alt_r[6:3] | $past(alt_hit[6:3]),
      alt_r[2:0]} || $past(alt_hit) == 7'h00)                   // RQ4
    else $error("flags not copied");

endmodule

// ---- tb/mkd_keys.sv ----
// Passive 8 x 8 key matrix with a pull-up on every line
`timescale 1ns/10ps
module mkd_keys (
  input  wire logic [63:0] keys_i,     // Pressed keys, bit row*8+col
  input  wire logic [7:0]  row_drv_i,  // Row drive values
  input  wire logic [7:0]  row_oe_n_i, // Row enables, low drives
  input  wire logic [7:0]  col_drv_i,  // Column drive values
  input  wire logic [7:0]  col_oe_n_i, // Column enables, low drives
  output logic      [7:0]  row_lvl_o,  // Row wire levels
  output logic      [7:0]  col_lvl_o   // Column wire levels
);
  // ------------------------------------------------------------
  // Wire resolution: low only where a driven-low line reaches it
  // ------------------------------------------------------------
  always_comb begin
    row_lvl_o = row_oe_n_i | row_drv_i;
    col_lvl_o = col_oe_n_i | col_drv_i;
    for (int r = 0; r < 8; r++) begin
      for (int c = 0; c < 8; c++) begin
        if (keys_i[r*8+c] && !col_oe_n_i[c] && !col_drv_i[c]) begin
          row_lvl_o[r] = 1'b0;
        end
        if (keys_i[r*8+c] && !row_oe_n_i[r] && !row_drv_i[r]) begin
          col_lvl_o[c] = 1'b0;
        end
      end
    end
  end
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the keypad decoder over Wishbone
`timescale 1ns/10ps
module tb_top;
  localparam int DBC = 20;
  localparam int LIMIT = 20000;
  logic        clk_i, rst_i, cyc, stb, we;
  logic [3:0]  adr, sel;
  logic [31:0] wdat, rd;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, irq_o;
  logic [7:0]  row_i, row_o, row_oe_n_o, col_i, col_o, col_oe_n_o;
  logic [63:0] keys;
  logic        bad_lvl, both_drv;
  int          fails, n_tests, cycles, cnt;
  int          er [8] = '{7, 0, 2, 0, 7, 0, 3, 5};
  int          ec [8] = '{7, 0, 5, 0, 0, 7, 1, 2};
  logic [6:0]  efl [8] = '{7'h00, 7'h7F, 7'h7F, 7'h78,
                           7'h78, 7'h00, 7'h00, 7'h00};

  mkd_top #(.DEBOUNCE_CYC(DBC)) mkd_top_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
    .row_i(row_i), .row_o(row_o), .row_oe_n_o(row_oe_n_o),
    .col_i(col_i), .col_o(col_o), .col_oe_n_o(col_oe_n_o));

  mkd_keys mkd_keys_i (
    .keys_i(keys), .row_drv_i(row_o), .row_oe_n_i(row_oe_n_o),
    .col_drv_i(col_o), .col_oe_n_i(col_oe_n_o),
    .row_lvl_o(row_i), .col_lvl_o(col_i));

  // ------------------------------------------------------------
  // Clock, timeout and pin monitor
  // ------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      end_of_test();
    end
    if (!rst_i && (row_o !== 8'h00 || col_o !== 8'h00)) bad_lvl = 1'b1;
    if (!rst_i && (~row_oe_n_o) != 8'h00 && (~col_oe_n_o) != 8'h00) begin
      both_drv = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [3:0] s, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= s;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] m,
                        input logic [31:0] exp);
    wb(1'b0, a, 4'hF, 32'h0000_0000);
    check(rd & m, exp);
  endtask

  // Wait for a status bit with bus polls, bounded
  task automatic wait_stat(input int b);
    int n;
    n = 0;
    do begin
      wb(1'b0, 4'h8, 4'hF, 32'h0000_0000);
      n++;
    end while (rd[b] !== 1'b1 && n < 100);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 4'h0;
    sel = 4'h0;
    wdat = 32'h0000_0000;
    keys = 64'h0;
    bad_lvl = 1'b0;
    both_drv = 1'b0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check(row_oe_n_o, 8'h00);
    check(col_oe_n_o, 8'hFF);
    check(irq_o, 1'b0);
    rd_chk(4'h0, 32'hFFFF_FFFF, 32'h0000_0000);
    rd_chk(4'h4, 32'hFFFF_FFFF, 32'h0000_0000);
    rd_chk(4'h8, 32'hFFFF_FFFF, 32'h0000_0000);
    rd_chk(4'hC, 32'hFFFF_FFFF, 32'h0000_0000);
    rd_chk(4'h6, 32'hFFFF_FFFF, 32'h0000_0000);
    for (int i = 0; i < 8; i++) begin
      if (i == 1) wb(1'b1, 4'hC, 4'h1, 32'h0000_0003);
      @(posedge clk_i);
      keys <= (i == 6) ? ((64'h1 << 28) | (64'h1 << 49))
                       : (64'h1 << (er[i] * 8 + ec[i]));
      cnt = 0;
      do begin
        @(posedge clk_i);
        cnt++;
      end while (col_oe_n_o === 8'hFF && cnt < 300);
      check((cnt >= DBC + 2) ? 1 : 0, 1);
      wait_stat(0);
      check(rd[1:0], 2'h1);
      check(irq_o, (i > 0) ? 1'b1 : 1'b0);
      keys <= 64'h0;
      // Code is row*8+col; a consumer table keeps eight slots per row
      rd_chk(4'h0, 32'h0000_803F, 32'h8000 | (er[i] * 8 + ec[i]));
      rd_chk(4'h4, 32'h0000_007F, {25'h0, efl[i]});
      wb(1'b1, 4'h0, 4'h2, 32'h0000_0000);
      rd_chk(4'h0, 32'h0000_803F, er[i] * 8 + ec[i]);
      wb(1'b1, 4'h8, 4'h1, 32'h0000_0003);
      rd_chk(4'h8, 32'h0000_0003, 32'h0000_0000);
      check(irq_o, 1'b0);
    end
    // Press too short to outlast the debounce time
    @(posedge clk_i);
    keys <= 64'h1 << 9;
    repeat (4) @(posedge clk_i);
    keys <= 64'h0;
    wait_stat(1);
    check(rd[1:0], 2'h2);
    check(irq_o, 1'b1);
    rd_chk(4'h0, 32'h0000_803F, 32'h0000_002A);
    rd_chk(4'h4, 32'h0000_007F, 32'h0000_0000);
    wb(1'b1, 4'h8, 4'h1, 32'h0000_0003);
    rd_chk(4'h8, 32'h0000_0003, 32'h0000_0000);
    check(bad_lvl, 1'b0);
    check(both_drv, 1'b0);
    end_of_test();
  end
endmodule
